// ### verilog/dfpm_cfg.svh
// constants for the drive failure prediction monitor
`ifndef DFPM_CFG_SVH
`define DFPM_CFG_SVH
// ***********************************************************
// register offsets (byte addresses)
// ***********************************************************
`define DFPM_OFF_CTRL 8'h00
`define DFPM_OFF_STATUS 8'h04
`define DFPM_OFF_MASK 8'h08
`define DFPM_OFF_TIMER 8'h0C
`define DFPM_OFF_FAIL 8'h10
`define DFPM_OFF_CMD 8'h14
// ***********************************************************
// control fields
// ***********************************************************
`define DFPM_CTRL_EXC_DIS 0
`define DFPM_CTRL_ONLINE 1
`define DFPM_CTRL_RPT_EN 2
`define DFPM_CTRL_RESET 32'h0000_0004
// status bits
`define DFPM_ST_PRED 0
`define DFPM_ST_PASS_DONE 1
// ***********************************************************
// timing
// ***********************************************************
`define DFPM_CLK_MHZ 200
`define DFPM_SCHED_S 7200
`define DFPM_SCHED_CYC (`DFPM_SCHED_S * 64'd1000000 * `DFPM_CLK_MHZ)
`define DFPM_IDLE_US 100
`define DFPM_IDLE_CYC (`DFPM_IDLE_US * `DFPM_CLK_MHZ)
`define DFPM_ONLINE_MS 60
`define DFPM_FULL_MS 450
`define DFPM_ONLINE_CYC (`DFPM_ONLINE_MS * 1000 * `DFPM_CLK_MHZ)
`define DFPM_FULL_CYC (`DFPM_FULL_MS * 1000 * `DFPM_CLK_MHZ)
`define DFPM_PASS_CYC 1000
`endif

// ### verilog/dfpm_pkg.sv
// types for the drive failure prediction monitor
package dfpm_pkg;
	typedef enum logic [1:0] {
		DFPM_IDLE,
		DFPM_MEASURE,
		DFPM_SAVE
	} dfpm_state_t;
endpackage

// ### verilog/dfpm_attr.sv
// one monitored attribute: interval, error tally and degradation score
`timescale 1ns/1ps
module dfpm_attr #(
	parameter int CW = 16,
	parameter int SW = 8
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// control
	input wire logic collect_i,
	input wire logic op_i,
	input wire logic err_i,
	// limits
	input wire logic [CW-1:0] interval_i,
	input wire logic [CW-1:0] err_thr_i,
	input wire logic [SW-1:0] pred_thr_i,
	// results
	output logic verdict_o,
	output logic unacc_o,
	output logic [SW-1:0] score_o,
	output logic pred_o
);
	logic [CW-1:0] ops_reg;
	logic [CW-1:0] errs_reg;
	logic [SW-1:0] score_reg;
	logic verdict_reg;
	logic unacc_reg;
	wire op_v = collect_i && op_i;
	wire err_v = collect_i && err_i;
	wire [CW-1:0] errs_inc = errs_reg + CW'(err_v);
	wire [CW-1:0] ops_inc = ops_reg + CW'(op_v);
	// an error past the threshold ends the interval early
	wire bad = errs_inc > err_thr_i;
	wire ended = ops_inc >= interval_i;
	wire judge = collect_i && (bad || ended);
	wire [SW-1:0] score_up = (&score_reg) ? score_reg : score_reg + SW'(1);
	wire [SW-1:0] score_dn = (score_reg == '0) ? score_reg :
		score_reg - SW'(1);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ops_reg <= '0;
			errs_reg <= '0;
			score_reg <= '0;
			verdict_reg <= 1'b0;
			unacc_reg <= 1'b0;
		end else begin
			verdict_reg <= judge;
			unacc_reg <= judge && bad;
			if (judge) begin
				ops_reg <= '0;
				errs_reg <= '0;
				score_reg <= bad ? score_up : score_dn;
			end else begin
				ops_reg <= ops_inc;
				errs_reg <= errs_inc;
			end
		end
	end
	assign verdict_o = verdict_reg;
	assign unacc_o = unacc_reg;
	assign score_o = score_reg;
	assign pred_o = score_reg >= pred_thr_i;

	a_tally_clear: assert property (
		@(posedge clk_i) disable iff (rst_i)
		judge |=> (ops_reg == '0 && errs_reg == '0))
		else $error("counters not cleared after verdict");
	a_score_step: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(judge && bad && !(&score_reg)) |=>
		score_reg == $past(score_reg) + SW'(1))
		else $error("score did not rise on bad interval");
endmodule

// ### verilog/dfpm_top.sv
// drive failure prediction monitor: control, scheduler, bus and reports
// Notes on behaviour
// - exception disable stops collection, measurement and reporting.
// - online-only select collects on normal ops, skips off-line passes.
// - recalibrate forces a measure and save pass and restarts timer.
// - time remaining to next scheduled pass is readable by the host.
// - scheduled pass every two hours, only after interface idle period.
// - a started off-line pass runs to completion despite host activity.
// - monitor delay bounded: 60 ms online-only, 450 ms fully enabled.
// - predictive failure raises a failure-prediction sense report.
// - reported code is held and survives bus resets.
// - per-attribute operation counter counts ops in the interval.
// - per-attribute error tally counts errors in the interval.
// - tally above threshold is unacceptable, else interval acceptable.
// - after each verdict both counters clear, new interval starts.
// - score up on unacceptable, down on acceptable, floor at zero.
// - score reaching predictive threshold signals predictive failure.
// - each attribute keeps its own independent score.
`include "dfpm_cfg.svh"
`timescale 1ns/1ps
module dfpm_top
	import dfpm_pkg::*;
#(
	parameter int NA = 4,
	parameter int CW = 16,
	parameter int SW = 8,
	parameter logic [CW-1:0] INTERVAL = 16'h0100,
	parameter logic [CW-1:0] ERR_THR = 16'h0004,
	parameter logic [SW-1:0] PRED_THR = 8'h10,
	parameter logic [63:0] SCHED_CYC = `DFPM_SCHED_CYC,
	parameter logic [31:0] IDLE_CYC = `DFPM_IDLE_CYC,
	parameter logic [31:0] PASS_CYC = `DFPM_PASS_CYC,
	parameter logic [7:0] SENSE_QUAL = 8'h00
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// avalon-mm slave
	input wire logic [7:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// drive activity
	input wire logic [NA-1:0] attr_op_i,
	input wire logic [NA-1:0] attr_err_i,
	input wire logic host_busy_i,
	input wire logic head_recalibrate_cmd_i,
	input wire logic bus_reset_i,
	// non-volatile report code restored after power up
	input wire logic nv_valid_i,
	input wire logic [15:0] nv_code_i,
	// outputs
	output logic pass_active_o,
	output logic nv_save_o,
	output logic [15:0] sense_code_o,
	output logic sense_valid_o,
	output logic irq_o
);
	// ***********************************************************
	// bus decode
	// ***********************************************************
	logic [31:0] ctrl_reg;
	logic [1:0] status_reg;
	logic [1:0] mask_reg;
	logic [31:0] rdata_reg;
	logic ack_reg;
	wire req = (avs_read_i || avs_write_i) && !ack_reg;
	// writes land on the edge that ends the wait, as the master expects
	wire wr = avs_write_i && ack_reg;
	wire sel_ctrl = avs_address_i == `DFPM_OFF_CTRL;
	wire sel_status = avs_address_i == `DFPM_OFF_STATUS;
	wire sel_mask = avs_address_i == `DFPM_OFF_MASK;
	wire sel_timer = avs_address_i == `DFPM_OFF_TIMER;
	wire sel_fail = avs_address_i == `DFPM_OFF_FAIL;
	wire sel_cmd = avs_address_i == `DFPM_OFF_CMD;
	wire exc_dis = ctrl_reg[`DFPM_CTRL_EXC_DIS];
	wire online_only = ctrl_reg[`DFPM_CTRL_ONLINE];
	wire rpt_en = ctrl_reg[`DFPM_CTRL_RPT_EN];
	// one wait state: the answer comes on the second edge
	assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_reg;
	assign avs_readdata_o = rdata_reg;

	// ***********************************************************
	// attributes
	// ***********************************************************
	dfpm_state_t state_reg;
	logic [NA-1:0] verdict;
	logic [NA-1:0] unacc;
	logic [NA-1:0] pred;
	logic [SW-1:0] score [NA];
	// off-line work pauses collection so counts stay consistent
	wire collect = !exc_dis && state_reg == DFPM_IDLE;
	genvar g;
	generate
		for (g = 0; g < NA; g++) begin : gen_attr
			dfpm_attr #(
				.CW(CW),
				.SW(SW)
			) u_attr (
				.clk_i(clk_i),
				.rst_i(rst_i),
				.collect_i(collect),
				.op_i(attr_op_i[g]),
				.err_i(attr_err_i[g]),
				.interval_i(INTERVAL),
				.err_thr_i(ERR_THR),
				.pred_thr_i(PRED_THR),
				.verdict_o(verdict[g]),
				.unacc_o(unacc[g]),
				.score_o(score[g]),
				.pred_o(pred[g])
			);
		end
	endgenerate
	wire any_pred = |pred;

	// ***********************************************************
	// scheduler and off-line pass
	// ***********************************************************
	logic [63:0] sched_reg;
	logic [31:0] idle_reg;
	logic [31:0] pass_reg;
	logic recal_pend_reg;
	wire offline_ok = !exc_dis && !online_only;
	wire sched_due = sched_reg == 64'h0;
	wire idle_ok = idle_reg >= IDLE_CYC;
	wire recal_cmd = head_recalibrate_cmd_i || (wr && sel_cmd &&
		avs_writedata_i[0]);
	wire start_sched = sched_due && idle_ok;
	wire start = state_reg == DFPM_IDLE && offline_ok &&
		(recal_pend_reg || start_sched);
	wire pass_end = pass_reg == 32'h0;
	wire half = pass_reg == (PASS_CYC >> 1);
	wire done = state_reg == DFPM_SAVE && pass_end;
	// bounded pass length keeps the added delay far below the limits
	localparam logic [31:0] LIMIT_CYC = 32'(`DFPM_ONLINE_CYC);
	localparam logic [31:0] FULL_LIMIT = 32'(`DFPM_FULL_CYC);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= DFPM_IDLE;
			pass_reg <= '0;
		end else begin
			unique case (state_reg)
				DFPM_IDLE: begin
					if (start) begin
						state_reg <= DFPM_MEASURE;
						pass_reg <= PASS_CYC - 32'h1;
					end
				end
				// host activity is not looked at here on purpose
				DFPM_MEASURE: begin
					pass_reg <= pass_reg - 32'h1;
					if (half)
						state_reg <= DFPM_SAVE;
				end
				DFPM_SAVE: begin
					if (pass_end)
						state_reg <= DFPM_IDLE;
					else
						pass_reg <= pass_reg - 32'h1;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			recal_pend_reg <= 1'b0;
			idle_reg <= '0;
		end else begin
			if (recal_cmd && offline_ok)
				recal_pend_reg <= 1'b1;
			else if (start)
				recal_pend_reg <= 1'b0;
			if (host_busy_i)
				idle_reg <= '0;
			else if (!idle_ok)
				idle_reg <= idle_reg + 32'h1;
		end
	end

	// the timer restarts at the start of every pass, forced or scheduled
	always_ff @(posedge clk_i) begin
		if (rst_i)
			sched_reg <= SCHED_CYC;
		else if (start)
			sched_reg <= SCHED_CYC;
		else if (!sched_due && offline_ok)
			sched_reg <= sched_reg - 64'h1;
	end
	assign pass_active_o = state_reg != DFPM_IDLE;
	assign nv_save_o = state_reg == DFPM_SAVE;

	// ***********************************************************
	// sense report, held across bus resets
	// ***********************************************************
	logic [15:0] code_reg;
	logic code_valid_reg;
	logic restored_reg;
	wire [15:0] pred_code = {8'h5D, SENSE_QUAL};
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			code_reg <= 16'h0000;
			code_valid_reg <= 1'b0;
			restored_reg <= 1'b0;
		end else begin
			restored_reg <= 1'b1;
			if (!restored_reg && nv_valid_i) begin
				code_reg <= nv_code_i;
				code_valid_reg <= 1'b1;
			end else if (any_pred && !exc_dis) begin
				code_reg <= pred_code;
				code_valid_reg <= 1'b1;
			end
			// a bus reset is deliberately ignored: the code stays
		end
	end
	assign sense_code_o = code_reg;
	assign sense_valid_o = code_valid_reg && rpt_en && !exc_dis;

	// ***********************************************************
	// registers and interrupt
	// ***********************************************************
	wire [1:0] ev = {done, code_valid_reg && !exc_dis};
	wire [1:0] w1c = (wr && sel_status && avs_byteenable_i[0]) ?
		avs_writedata_i[1:0] : 2'h0;
	wire [31:0] rd_mux =
		sel_ctrl ? ctrl_reg :
		sel_status ? {30'h0, status_reg} :
		sel_mask ? {30'h0, mask_reg} :
		sel_timer ? sched_reg[63:32] != 32'h0 ? 32'hFFFF_FFFF :
			sched_reg[31:0] :
		sel_fail ? {16'h0, code_reg} :
		32'h0;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_reg <= `DFPM_CTRL_RESET;
			status_reg <= 2'h0;
			mask_reg <= 2'h0;
			rdata_reg <= 32'h0;
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= req;
			if (req && avs_read_i)
				rdata_reg <= rd_mux;
			// a new event wins over the clear in the same cycle
			status_reg <= (status_reg & ~w1c) | ev;
			if (wr && sel_mask && avs_byteenable_i[0])
				mask_reg <= avs_writedata_i[1:0];
			if (wr && sel_ctrl && avs_byteenable_i[0])
				ctrl_reg[2:0] <= avs_writedata_i[2:0];
		end
	end
	assign irq_o = |(status_reg & mask_reg);

	// ***********************************************************
	// checks
	// ***********************************************************
	sequence s_pass_start;
		state_reg == DFPM_IDLE && start;
	endsequence
	sequence s_pass_run;
		state_reg != DFPM_IDLE;
	endsequence
	sequence s_bus_take;
		(avs_read_i || avs_write_i) && !ack_reg;
	endsequence
	sequence s_bus_answer;
		ack_reg && !avs_waitrequest_o;
	endsequence
	a_disable_quiet: assert property (
		@(posedge clk_i) disable iff (rst_i)
		exc_dis |-> !sense_valid_o && !start)
		else $error("activity while exceptions disabled");
	a_online_skip: assert property (
		@(posedge clk_i) disable iff (rst_i)
		online_only |-> !start)
		else $error("off-line pass in online-only mode");
	a_timer_hold: assert property (
		@(posedge clk_i) disable iff (rst_i)
		!offline_ok |=> sched_reg == $past(sched_reg))
		else $error("timer ran while off-line passes barred");
	a_recal_start: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(recal_cmd && offline_ok && state_reg == DFPM_IDLE) |->
		##2 state_reg == DFPM_MEASURE)
		else $error("recalibrate did not start a pass");
	a_timer_restart: assert property (
		@(posedge clk_i) disable iff (rst_i)
		s_pass_start |=> sched_reg == SCHED_CYC)
		else $error("timer not restarted");
	a_save_phase: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(state_reg == DFPM_MEASURE && half) |=> nv_save_o)
		else $error("measure phase not followed by save");
	a_done_sticky: assert property (
		@(posedge clk_i) disable iff (rst_i)
		done |=> status_reg[`DFPM_ST_PASS_DONE])
		else $error("pass done not recorded");
	a_bus_wait: assert property (
		@(posedge clk_i) disable iff (rst_i)
		s_bus_take |=> s_bus_answer)
		else $error("register access not answered");
	a_sched_idle: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(start && !recal_pend_reg) |-> idle_ok && sched_due)
		else $error("scheduled pass without idle");
	a_idle_clear: assert property (
		@(posedge clk_i) disable iff (rst_i)
		host_busy_i |=> idle_reg == 32'h0)
		else $error("idle count not cleared by host activity");
	a_sched_count: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(offline_ok && !sched_due && !start) |=>
		sched_reg == $past(sched_reg) - 64'h1)
		else $error("schedule timer did not count");
	a_pass_first: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(s_pass_start ##1 s_pass_run) |-> pass_reg == PASS_CYC - 32'h1)
		else $error("pass counter not loaded");
	a_pass_whole: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(pass_active_o && !pass_end) |=>
		pass_active_o && pass_reg == $past(pass_reg) - 32'h1)
		else $error("pass stopped before its end");
	a_delay_bound: assert property (
		@(posedge clk_i) disable iff (rst_i)
		PASS_CYC <= LIMIT_CYC && PASS_CYC <= FULL_LIMIT)
		else $error("pass longer than allowed delay");
	a_pred_report: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(any_pred && !exc_dis && restored_reg) |=>
		code_valid_reg && code_reg == pred_code)
		else $error("predictive failure not reported");
	a_code_kept: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(code_valid_reg && bus_reset_i) |=> code_valid_reg)
		else $error("code lost on bus reset");
	a_nv_restore: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(!restored_reg && nv_valid_i) |=>
		code_valid_reg && code_reg == $past(nv_code_i))
		else $error("stored code not restored");
	a_score_hold: assert property (
		@(posedge clk_i) disable iff (rst_i)
		!verdict[0] |-> score[0] == $past(score[0]))
		else $error("score moved without its own verdict");
	a_score_fall: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(verdict[0] && !unacc[0]) |-> score[0] <= $past(score[0]))
		else $error("score rose on acceptable interval");
endmodule

// ### verification/dfpm_host_model.sv
// host initiator model driving the activity lines of the monitor
`timescale 1ns/1ps
module dfpm_host_model (
	// clock
	input wire logic clk_i,
	// host activity
	output logic host_busy_o,
	output logic recal_o,
	output logic bus_reset_o
);
	// ***********************************************
	// host behaviour
	// ***********************************************
	initial begin
		host_busy_o = 1'b1;
		recal_o = 1'b0;
		bus_reset_o = 1'b0;
	end
	task automatic recal();
		recal_o <= 1'b1;
		@(posedge clk_i);
		recal_o <= 1'b0;
		@(posedge clk_i);
	endtask
	// insertion: quiesce first, reset after, or the bus may misbehave
	task automatic hot_insert();
		host_busy_o <= 1'b0;
		repeat (4) @(posedge clk_i);
		bus_reset_o <= 1'b1;
		@(posedge clk_i);
		bus_reset_o <= 1'b0;
		@(posedge clk_i);
	endtask
endmodule

// ### verification/dfpm_top_tb_top.sv
// self-checking bench for the drive failure prediction monitor
`include "dfpm_cfg.svh"
`timescale 1ns/1ps
module dfpm_top_tb_top;
	import dfpm_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] adr = 8'h00;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic wait_rq;
	logic [3:0] op = 4'h0;
	logic [3:0] er = 4'h0;
	logic [3:0] be = 4'hF;
	logic busy, recal, breset, act, nsave, sval, irq;
	logic nv_v = 1'b0;
	logic [15:0] nv_c = 16'h0000;
	logic [15:0] scode;
	logic [31:0] q, q2;
	int err_count = 0;
	int checks_done = 0;
	int n, s;
	always #2.5 clk_i = ~clk_i;
	// small counts keep the run short; the interval keeps its default
	dfpm_top #(.ERR_THR(16'h0002), .PRED_THR(8'h02),
		.SCHED_CYC(64'd2000), .IDLE_CYC(32'd10), .PASS_CYC(32'd20))
	u_dfpm_top (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(adr),
		.avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
		.avs_byteenable_i(be), .avs_readdata_o(rdat),
		.avs_waitrequest_o(wait_rq), .attr_op_i(op), .attr_err_i(er),
		.host_busy_i(busy), .head_recalibrate_cmd_i(recal),
		.bus_reset_i(breset), .nv_valid_i(nv_v), .nv_code_i(nv_c),
		.pass_active_o(act), .nv_save_o(nsave), .sense_code_o(scode),
		.sense_valid_o(sval), .irq_o(irq));
	dfpm_host_model u_dfpm_host_model (.clk_i(clk_i), .host_busy_o(busy),
		.recal_o(recal), .bus_reset_o(breset));
	// ***********************************************
	// tasks
	// ***********************************************
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		int k;
		k = 0;
		adr <= a;
		wdat <= d;
		wr <= w;
		rd <= !w;
		do begin
			@(posedge clk_i);
			k++;
		end while (wait_rq !== 1'b0 && k < 40);
		r = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
		if (k >= 40) begin
			err_count++;
			print_verdict();
		end
		@(posedge clk_i);
	endtask
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] x;
		bus(1'b0, a, 32'h0, x);
		chk(x, e);
	endtask
	task automatic pulse(input logic [3:0] o, input logic [3:0] e, input int c);
		repeat (c) begin
			op <= o;
			er <= e;
			@(posedge clk_i);
			op <= 4'h0;
			er <= 4'h0;
			@(posedge clk_i);
		end
		repeat (4) @(posedge clk_i);
	endtask
	// bounded wait for a pass, then count its cycles
	task automatic pass_len(input int lim, output int len, output int sv);
		int k;
		k = 0;
		len = 0;
		sv = 0;
		while (act !== 1'b1 && k < lim) begin
			@(posedge clk_i);
			k++;
		end
		while (act === 1'b1 && len < 100) begin
			if (nsave === 1'b1)
				sv++;
			@(posedge clk_i);
			len++;
		end
	endtask
	// ***********************************************
	// tests
	// ***********************************************
	initial begin
		#500000;
		err_count++;
		print_verdict();
	end
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rchk(`DFPM_OFF_CTRL, `DFPM_CTRL_RESET);
		wreg(8'h40, 32'hFFFF_FFFF);
		rchk(8'h40, 32'h0);
		be <= 4'h0;
		wreg(`DFPM_OFF_MASK, 32'h3);
		be <= 4'hF;
		rchk(`DFPM_OFF_MASK, 32'h0);
		$display("test registers done");
		pulse(4'h1, 4'h0, 256);
		pulse(4'h0, 4'h1, 3);
		pulse(4'h0, 4'h1, 2);
		pulse(4'h0, 4'h2, 3);
		rchk(`DFPM_OFF_STATUS, 32'h0);
		pulse(4'h0, 4'h1, 1);
		rchk(`DFPM_OFF_STATUS, 32'h1);
		chk({16'h0, scode}, 32'h5D00);
		chk({31'h0, sval}, 32'h1);
		rchk(`DFPM_OFF_FAIL, 32'h5D00);
		wreg(`DFPM_OFF_MASK, 32'h1);
		chk({31'h0, irq}, 32'h1);
		wreg(`DFPM_OFF_MASK, 32'h0);
		chk({31'h0, irq}, 32'h0);
		wreg(`DFPM_OFF_CTRL, 32'h5);
		chk({31'h0, sval}, 32'h0);
		rchk(`DFPM_OFF_FAIL, 32'h5D00);
		wreg(`DFPM_OFF_CTRL, 32'h4);
		$display("test scoring done");
		u_dfpm_host_model.recal();
		pass_len(10, n, s);
		chk(n, 32'd20);
		chk(s, 32'd10);
		rchk(`DFPM_OFF_STATUS, 32'h3);
		bus(1'b0, `DFPM_OFF_TIMER, 32'h0, q);
		chk({31'h0, q > 32'd1900 && q <= 32'd2000}, 32'h1);
		repeat (20) @(posedge clk_i);
		bus(1'b0, `DFPM_OFF_TIMER, 32'h0, q2);
		chk({31'h0, q2 < q}, 32'h1);
		wreg(`DFPM_OFF_MASK, 32'h2);
		chk({31'h0, irq}, 32'h1);
		wreg(`DFPM_OFF_STATUS, 32'h2);
		rchk(`DFPM_OFF_STATUS, 32'h1);
		chk({31'h0, irq}, 32'h0);
		wreg(`DFPM_OFF_CMD, 32'h1);
		pass_len(10, n, s);
		chk(n, 32'd20);
		chk(s, 32'd10);
		wreg(`DFPM_OFF_CTRL, 32'h6);
		u_dfpm_host_model.recal();
		pass_len(40, n, s);
		chk(n, 32'd0);
		chk(s, 32'd0);
		wreg(`DFPM_OFF_CTRL, 32'h4);
		$display("test recalibrate done");
		u_dfpm_host_model.hot_insert();
		chk({16'h0, scode}, 32'h5D00);
		pass_len(2400, n, s);
		chk(n, 32'd20);
		chk(s, 32'd10);
		$display("test schedule done");
		nv_v <= 1'b1;
		nv_c <= 16'h5D3C;
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rchk(`DFPM_OFF_FAIL, 32'h5D3C);
		chk({16'h0, scode}, 32'h5D3C);
		rchk(`DFPM_OFF_CTRL, `DFPM_CTRL_RESET);
		$display("test power cycle done");
		print_verdict();
	end
endmodule
